// file: mas_host.sv
// Host controller model: convert start pulses and serial frames
`timescale 1ns/1ps
`default_nettype none
module mas_host (
    input  wire logic ref_clk,
    input  wire logic busy,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output logic      convert_start,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi
);
    int oe_cnt;

    //============================================================
    // Idle levels; the serial clock stands still between frames
    initial
    begin
        convert_start = 1'h0;
        cs_n = 1'h1;
        sck = 1'h0;
        sdi = 1'h0;
    end

    // Pulse is long on both levels so the synchroniser cannot miss it
    task automatic convert();
        @(posedge ref_clk);
        #1 convert_start = 1'h1;
        repeat (4) @(posedge ref_clk);
        #1 convert_start = 1'h0;
        repeat (4) @(posedge ref_clk);
    endtask : convert

    // Frame on a 15 ns serial clock, sampling output on falling edges
    task automatic frame(input logic [31:0] tx, input int n,
                         output logic [31:0] rx);
        int i;
        rx = 32'h0;
        oe_cnt = 0;
        wait (busy === 1'h0);
        #3 cs_n = 1'h0;
        for (i = 0; i < n; i++)
        begin
            sdi = tx[31 - i];
            #7.5 sck = 1'h1;
            #7.5 sck = 1'h0;
            // Undriven output has no pull, so it reads as the inverse
            rx = {rx[30:0], sdo_oe ? sdo : ~sdo};
            if (sdo_oe === 1'h1)
                oe_cnt++;
        end
        #7.5 cs_n = 1'h1;
        sdi = ~sdi; // Released line has no pull, so it moves
    endtask : frame
endmodule : mas_host
`default_nettype wire

// file: mas_pkg.sv
// Shared constants and types for the multichannel sequencer control block
//============================================================
package mas_pkg;

    //============================================================
    // Timing
    localparam int CLK_MHZ   = 250;
    localparam int HOLD_NS   = 300;  // Conditioning phase
    localparam int QUANT_NS  = 400;  // Quantizing phase
    localparam int HOLD_CYC  = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int QUANT_CYC = (QUANT_NS * CLK_MHZ + 999) / 1000;

    //============================================================
    // Configuration word layout
    localparam int CFG_W      = 16;
    localparam int B_WRITE    = 15;
    localparam int B_SEQ_HI   = 14;
    localparam int B_SEQ_LO   = 13;
    localparam int B_CH_HI    = 12;
    localparam int B_CH_LO    = 10;
    localparam int B_GAIN_HI  = 9;
    localparam int B_GAIN_LO  = 7;
    localparam int B_PAIR     = 6;
    localparam int B_AUX      = 5;
    localparam int B_TEMP     = 4;
    localparam int B_RB       = 3;
    localparam logic [1:0] SEQ_OFF  = 2'h0;
    localparam logic [1:0] SEQ_RUN  = 2'h1;
    localparam logic [1:0] SEQ_GAIN = 2'h3;  // Loads one gain table entry
    localparam logic [2:0] GAIN_DEF = 3'h7;
    localparam logic [15:0] CFG_DEF = 16'h0388;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;
    localparam logic [2:0] CH_ZERO  = 3'h0;
    localparam logic [3:0] PAIR_STEP = 4'h2;
    localparam logic [3:0] ONE_STEP  = 4'h1;
    localparam int FRAME_BITS = 32;

    //============================================================
    // Types
    typedef enum logic [2:0] {
        CV_TRACK = 3'b001,
        CV_HOLD  = 3'b010,
        CV_QUANT = 3'b100
    } mas_conv_t;

    typedef enum logic [2:0] {
        SL_IN   = 3'b001,
        SL_AUX  = 3'b010,
        SL_TEMP = 3'b100
    } mas_slot_t;

endpackage : mas_pkg

// file: mas_spi_link.sv
// Serial port on the link clock: config in, result and readback out
`timescale 1ns/1ps
`default_nettype none
module mas_spi_link (
    input  wire logic        sck,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic [15:0] result_word,
    input  wire logic [15:0] cfg_word,
    input  wire logic        rb_en,
    output logic [15:0]      rx_word,
    output logic             rx_tgl
);
    typedef struct packed {
        logic [5:0]  cnt;
        logic [31:0] tx;
        logic [14:0] rx;
        logic        sdo;
        logic        rb;
    } mas_frame_t;

    typedef struct packed {
        logic [15:0] word;
        logic        tgl;
    } mas_keep_t;

    mas_frame_t fr_ff;
    mas_frame_t nxt_fr;
    mas_keep_t  kp_ff;
    mas_keep_t  nxt_kp;
    logic       frame_rst_n;

    // Frame state dies with chip select; sck may stop between frames
    assign frame_rst_n = rst_n & ~cs_n;

    //============================================================
    // Shift on rising sck; words are quiet since busy is low
    always_comb
    begin
        nxt_fr = fr_ff;
        nxt_kp = kp_ff;
        if (fr_ff.cnt == 6'h00)
        begin
            // Snapshot on first edge; stable outside busy
            nxt_fr.tx  = {result_word[14:0], cfg_word, 1'b0};
            nxt_fr.sdo = result_word[15];
            nxt_fr.rb  = rb_en;
        end
        else
        begin
            nxt_fr.sdo = fr_ff.tx[31];
            nxt_fr.tx  = {fr_ff.tx[30:0], 1'b0};
        end
        if (fr_ff.cnt < 6'(mas_pkg::FRAME_BITS))
        begin
            nxt_fr.cnt = fr_ff.cnt + 6'h01;
        end
        nxt_fr.rx = {fr_ff.rx[13:0], sdi};
        if (fr_ff.cnt == 6'(mas_pkg::CFG_W - 1))
        begin
            nxt_kp.word = {fr_ff.rx, sdi};
            nxt_kp.tgl  = ~kp_ff.tgl;
        end
    end

    always_ff @(posedge sck or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            fr_ff <= '0;
        end
        else
        begin
            fr_ff <= nxt_fr;
        end
    end

    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kp_ff <= '0;
        end
        else
        begin
            kp_ff <= nxt_kp;
        end
    end

    //============================================================
    // Readback half is released only when enabled
    assign sdo    = fr_ff.sdo;
    assign sdo_oe = ~cs_n & ((fr_ff.cnt <= 6'(mas_pkg::CFG_W))
                    | fr_ff.rb);
    assign rx_word = kp_ff.word;
    assign rx_tgl  = kp_ff.tgl;
endmodule : mas_spi_link
`default_nettype wire

// file: mas_sync.sv
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mas_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } mas_sync_t;

    mas_sync_t st_ff;
    mas_sync_t nxt_st;

    //============================================================
    // Next state; s1 feeds only s2 to keep metastability contained
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.lvl;
endmodule : mas_sync
`default_nettype wire

// file: mas_top.sv
// Conversion timing, channel sequencer and result coding
`timescale 1ns/1ps
`default_nettype none
module mas_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        convert_start,
    input  wire logic        power_down_input,
    input  wire logic [15:0] core_code,
    output logic             busy,
    output logic             hold,
    output logic             quantize,
    output logic [2:0]       first_analog_channel,
    output logic             pair_sel,
    output logic             aux_sel,
    output logic             temp_sel,
    output logic [2:0]       gain_amplifier_code,
    output logic             seq_running,
    output logic [15:0]      result
);
    typedef struct packed {
        mas_pkg::mas_conv_t cv;
        logic [7:0]         cnt;
        logic               busy;
        logic [15:0]        result;
        logic [15:0]        cfg;
        logic               run;
        mas_pkg::mas_slot_t slot;
        logic [2:0]         pos;
        logic [23:0]        gtab;
        logic               start_lvl;
        logic               tgl_seen;
    } mas_top_t;

    mas_top_t    st_ff;
    mas_top_t    nxt_st;
    logic        start_sync;
    logic        tgl_sync;
    logic        sleep_sync;
    logic [15:0] rx_word;
    logic        rx_tgl;
    logic        start_rise;
    logic        cfg_new;
    logic [2:0]  last_ch;
    logic [3:0]  step_sum;
    logic [2:0]  cur_gain;

    //============================================================
    // Pin and crossing synchronisers
    mas_sync u_start_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (convert_start),
        .q     (start_sync)
    );

    // Power-down pin is asynchronous too, so it crosses the same way
    mas_sync u_sleep_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (power_down_input),
        .q     (sleep_sync)
    );

    // Toggle crossing: word is steady for a frame after the toggle
    mas_sync u_cfg_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (rx_tgl),
        .q     (tgl_sync)
    );

    //============================================================
    // Serial port on its own clock
    mas_spi_link u_link (
        .sck         (sck),
        .rst_n       (rst_n),
        .cs_n        (cs_n),
        .sdi         (sdi),
        .sdo         (sdo),
        .sdo_oe      (sdo_oe),
        .result_word (st_ff.result),
        .cfg_word    (st_ff.cfg),
        .rb_en       (st_ff.cfg[mas_pkg::B_RB]),
        .rx_word     (rx_word),
        .rx_tgl      (rx_tgl)
    );

    //============================================================
    // Events seen in the core domain
    assign start_rise = start_sync & ~st_ff.start_lvl;
    assign cfg_new  = (tgl_sync != st_ff.tgl_seen)
                    & rx_word[mas_pkg::B_WRITE];
    assign last_ch  = st_ff.cfg[mas_pkg::B_CH_HI:mas_pkg::B_CH_LO];
    assign step_sum = {1'b0, st_ff.pos}
                    + (st_ff.cfg[mas_pkg::B_PAIR] ?
                       mas_pkg::PAIR_STEP : mas_pkg::ONE_STEP);
    assign cur_gain = st_ff.gtab[st_ff.pos * 3 +: 3];

    //============================================================
    // Next state of conversion, sequencer and configuration
    always_comb
    begin
        logic        key_chg;
        logic [1:0]  seq;
        logic [2:0]  wch;
        key_chg = 1'b0;
        seq     = rx_word[mas_pkg::B_SEQ_HI:mas_pkg::B_SEQ_LO];
        wch     = rx_word[mas_pkg::B_CH_HI:mas_pkg::B_CH_LO];
        nxt_st  = st_ff;
        nxt_st.start_lvl = start_sync;
        nxt_st.tgl_seen = tgl_sync;

        // Conversion phases, timed from the internal clock only
        case (st_ff.cv)
            mas_pkg::CV_TRACK:
            begin
                // Edges while converting are dropped, not queued
                if (start_rise && !sleep_sync)
                begin
                    nxt_st.cv   = mas_pkg::CV_HOLD;
                    nxt_st.cnt  = 8'(mas_pkg::HOLD_CYC - 1);
                    nxt_st.busy = 1'b1;
                end
            end
            mas_pkg::CV_HOLD:
            begin
                if (st_ff.cnt == 8'h00)
                begin
                    nxt_st.cv  = mas_pkg::CV_QUANT;
                    nxt_st.cnt = 8'(mas_pkg::QUANT_CYC - 1);
                    if (st_ff.run)
                    begin
                        // Advance once the sample is held
                        case (st_ff.slot)
                            mas_pkg::SL_IN:
                            begin
                                if (step_sum > {1'b0, last_ch})
                                begin
                                    if (st_ff.cfg[mas_pkg::B_AUX])
                                    begin
                                        nxt_st.slot = mas_pkg::SL_AUX;
                                    end
                                    else if (st_ff.cfg[mas_pkg::B_TEMP])
                                    begin
                                        nxt_st.slot = mas_pkg::SL_TEMP;
                                    end
                                    nxt_st.pos = mas_pkg::CH_ZERO;
                                end
                                else
                                begin
                                    nxt_st.pos = step_sum[2:0];
                                end
                            end
                            mas_pkg::SL_AUX:
                            begin
                                // Each enabled slot takes one turn per lap
                                nxt_st.slot = st_ff.cfg[mas_pkg::B_TEMP] ?
                                    mas_pkg::SL_TEMP : mas_pkg::SL_IN;
                                nxt_st.pos  = mas_pkg::CH_ZERO;
                            end
                            default:
                            begin
                                nxt_st.slot = mas_pkg::SL_IN;
                                nxt_st.pos  = mas_pkg::CH_ZERO;
                            end
                        endcase
                    end
                end
                else
                begin
                    nxt_st.cnt = st_ff.cnt - 8'h01;
                end
            end
            mas_pkg::CV_QUANT:
            begin
                if (st_ff.cnt == 8'h00)
                begin
                    // Offset binary core code to twos complement
                    nxt_st.result = core_code ^ mas_pkg::SIGN_FLIP;
                    nxt_st.busy   = 1'b0;
                    nxt_st.cv     = mas_pkg::CV_TRACK;
                end
                else
                begin
                    nxt_st.cnt = st_ff.cnt - 8'h01;
                end
            end
            default:
            begin
                nxt_st.cv   = mas_pkg::CV_TRACK;
                nxt_st.busy = 1'b0;
            end
        endcase

        // Configuration write wins over a same-cycle advance
        if (cfg_new)
        begin
            if (seq == mas_pkg::SEQ_GAIN)
            begin
                nxt_st.gtab[wch * 3 +: 3] =
                    rx_word[mas_pkg::B_GAIN_HI:mas_pkg::B_GAIN_LO];
            end
            else
            begin
                key_chg = (rx_word[mas_pkg::B_SEQ_HI:mas_pkg::B_PAIR]
                    != st_ff.cfg[mas_pkg::B_SEQ_HI:mas_pkg::B_PAIR])
                    || (rx_word[mas_pkg::B_AUX:mas_pkg::B_TEMP]
                    != st_ff.cfg[mas_pkg::B_AUX:mas_pkg::B_TEMP]);
                nxt_st.cfg = rx_word;
                if (rx_word[mas_pkg::B_PAIR])
                begin
                    // Pair mode keeps the positive input even
                    nxt_st.cfg[mas_pkg::B_CH_LO] = 1'b0;
                end
                nxt_st.run = (seq == mas_pkg::SEQ_RUN);
                if (!st_ff.run || key_chg)
                begin
                    nxt_st.pos  = mas_pkg::CH_ZERO;
                    nxt_st.slot = mas_pkg::SL_IN;
                end
            end
        end
    end

    //============================================================
    // State register; reset restores defaults and stops scanning
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff      <= '0;
            st_ff.cv   <= mas_pkg::CV_TRACK;
            st_ff.slot <= mas_pkg::SL_IN;
            st_ff.cfg  <= mas_pkg::CFG_DEF;
            st_ff.gtab <= {8{mas_pkg::GAIN_DEF}};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    //============================================================
    // Outputs to the analog front end and status
    assign busy     = st_ff.busy;
    assign hold     = (st_ff.cv == mas_pkg::CV_HOLD);
    assign quantize = (st_ff.cv == mas_pkg::CV_QUANT);
    assign result   = st_ff.result;
    assign seq_running = st_ff.run;
    assign pair_sel = st_ff.cfg[mas_pkg::B_PAIR];
    assign aux_sel  = st_ff.run ? (st_ff.slot == mas_pkg::SL_AUX)
                                : st_ff.cfg[mas_pkg::B_AUX];
    assign temp_sel = st_ff.run ? (st_ff.slot == mas_pkg::SL_TEMP)
                                : st_ff.cfg[mas_pkg::B_TEMP];
    // Manual mode uses the channel field directly
    assign first_analog_channel = st_ff.run ? st_ff.pos : last_ch;
    assign gain_amplifier_code  = st_ff.run ? cur_gain
        : st_ff.cfg[mas_pkg::B_GAIN_HI:mas_pkg::B_GAIN_LO];
endmodule : mas_top
`default_nettype wire

// file: mas_top_props.sv
// Concurrent checks on the sequencer control block ports
`timescale 1ns/1ps
`default_nettype none
module mas_top_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        sdo_oe,
    input wire logic        power_down_input,
    input wire logic [15:0] core_code,
    input wire logic        busy,
    input wire logic        hold,
    input wire logic        quantize,
    input wire logic [2:0]  first_analog_channel,
    input wire logic [2:0]  gain_amplifier_code,
    input wire logic        seq_running,
    input wire logic [15:0] result
);
    //============================================================
    // Conversion phases, all timed on the core clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_busy_enters_hold: assert property ($rose(busy) |-> hold && !quantize)
        else $error("busy rose without hold phase");
    a_hold_then_quant: assert property ($rose(hold) |-> ##75 (!hold && quantize))
        else $error("hold phase length wrong");
    a_quant_then_done: assert property ($rose(quantize) |-> ##100 (!quantize && !busy))
        else $error("quantize phase length wrong");
    a_result_twos_comp: assert property ($fell(busy) |-> result == ($past(core_code) ^ 16'h8000))
        else $error("result not twos complement of core code");
    a_result_holds: assert property (!$fell(busy) |-> $stable(result))
        else $error("result changed outside conversion end");
    a_reset_defaults: assert property ($rose(rst_n) |-> gain_amplifier_code == 3'h7 && !seq_running && !busy)
        else $error("state after reset not default");
    a_sleep_blocks_conv: assert property
        ((power_down_input && !busy) [*5] |=> !busy)
        else $error("conversion started in power down");
    a_oe_in_frame: assert property (sdo_oe |-> !cs_n)
        else $error("serial output driven outside a frame");
    a_seq_starts_zero: assert property ($rose(seq_running) |-> first_analog_channel == 3'h0)
        else $error("sequencer did not start at channel zero");

    // Main scenarios seen at least once
    c_conv_done: cover property ($fell(busy));
    c_seq_start: cover property ($rose(seq_running));
    c_serial_out: cover property ($rose(sdo_oe));
endmodule : mas_top_props

bind mas_top mas_top_props u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sdo_oe(sdo_oe),
    .power_down_input(power_down_input), .core_code(core_code),
    .busy(busy), .hold(hold), .quantize(quantize),
    .first_analog_channel(first_analog_channel),
    .gain_amplifier_code(gain_amplifier_code),
    .seq_running(seq_running), .result(result)
);
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the sequencer control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        power_down_input = 1'h0;
    logic [15:0] core_code = 16'h0;
    logic        sck, cs_n, sdi, sdo, sdo_oe, convert_start, busy;
    logic        hold, quantize, pair_sel, aux_sel, temp_sel, seq_running;
    logic [2:0]  chan, gain;
    logic [15:0] result;
    logic [31:0] rx;
    logic [2:0]  gtab [8] = '{3'h5, 3'h0, 3'h3, 3'h1, 3'h4, 3'h2, 3'h7, 3'h0};
    logic [15:0] corner [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          seed = 40;
    int          k;

    always #2 ref_clk = ~ref_clk;

    mas_top DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .convert_start(convert_start), .power_down_input(power_down_input),
        .core_code(core_code), .busy(busy), .hold(hold),
        .quantize(quantize), .first_analog_channel(chan),
        .pair_sel(pair_sel), .aux_sel(aux_sel), .temp_sel(temp_sel),
        .gain_amplifier_code(gain), .seq_running(seq_running),
        .result(result)
    );

    mas_host u_host (
        .ref_clk(ref_clk), .busy(busy), .sdo(sdo), .sdo_oe(sdo_oe),
        .convert_start(convert_start), .cs_n(cs_n), .sck(sck), .sdi(sdi)
    );

    //============================================================
    // Comparison, expectations and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h",
                     $time, what, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    function automatic logic [15:0] cfg(logic [1:0] sq, logic [2:0] ch,
        logic [2:0] g, logic pr, logic ax, logic tp, logic rb);
        return {1'h1, sq, ch, g, pr, ax, tp, rb, 3'h0};
    endfunction : cfg

    // Slot in a lap: channels by step, then aux, then temperature
    function automatic logic [4:0] scan_slot(int k, int last, int step,
                                             bit ax, bit tp);
        int n;
        int p;
        n = last / step + 1 + ax + tp;
        p = k % n;
        if (p * step <= last)
            return {2'h0, 3'(p * step)};
        if (ax && p == last / step + 1)
            return 5'h10;
        return 5'h08;
    endfunction : scan_slot

    // Hang guard, far beyond the planned run length
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            stop_test();
        end
    end

    //============================================================
    // Bus-level helpers
    task automatic wr(input logic [15:0] w);
        u_host.frame({w, 16'h0}, 16, rx);
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic conv(input logic [15:0] c);
        int n;
        @(posedge ref_clk);
        #1 core_code = c;
        u_host.convert();
        n = 0;
        while (busy !== 1'h0 && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        #1;
        check(busy, 1'h0, "busy end");
    endtask : conv

    // Start a scan, then step through conversions with no rewrites
    task automatic scan(input logic [15:0] w, input int last, step,
                        input bit ax, tp, input int num);
        int i;
        wr(w);
        check(pair_sel, w[mas_pkg::B_PAIR], "pair mode");
        for (i = 0; i <= num; i++)
        begin
            if (i > 0)
                conv(16'($random(seed)));
            check({aux_sel, temp_sel, (aux_sel | temp_sel) ? 3'h0 : chan},
                  scan_slot(i, last, step, ax, tp), "scan slot");
            if (!aux_sel && !temp_sel)
                check(gain, gtab[chan], "scan gain");
        end
        $display("test scan done");
    endtask : scan

    //============================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        check({seq_running, busy, chan, gain}, 8'h07, "reset state");
        check(result, 16'h0, "reset result");
        for (k = 0; k < 8; k++)
        begin
            conv(k < 4 ? corner[k] : 16'($random(seed)));
            check(result, core_code ^ mas_pkg::SIGN_FLIP, "code");
            u_host.frame(32'h0, 32, rx);
            check(rx, {core_code ^ 16'h8000, mas_pkg::CFG_DEF}, "readout");
        end
        $display("test code map done");
        for (k = 0; k < 8; k++)
            if (k != 6)
            begin
                wr(cfg(2'h0, 3'(k), 3'(k), 1'h0, 1'h0, 1'h0, 1'h1));
                check({chan, gain}, {3'(k), 3'(k)}, "gain code");
            end
        wr(cfg(2'h0, 3'h1, 3'h0, 1'h0, 1'h0, 1'h0, 1'h1) & 16'h7FFF);
        check({chan, gain}, 6'h3F, "write bit clear");
        wr(cfg(2'h0, 3'h0, 3'h7, 1'h0, 1'h0, 1'h0, 1'h0));
        u_host.frame(32'h0, 32, rx);
        check(32'(u_host.oe_cnt), 32'h10, "readback off");
        wr(cfg(2'h0, 3'h0, 3'h7, 1'h0, 1'h0, 1'h0, 1'h1));
        u_host.frame(32'h0, 32, rx);
        check(32'(u_host.oe_cnt), 32'h20, "readback on");
        $display("test config done");
        for (k = 0; k < 8; k++)
            wr(cfg(mas_pkg::SEQ_GAIN, 3'(k), gtab[k], 1'h0, 1'h0, 1'h0, 1'h1));
        scan(cfg(mas_pkg::SEQ_RUN, 3'h3, 3'h7, 1'h0, 1'h0, 1'h0, 1'h1), 3, 1, 0, 0, 9);
        scan(cfg(mas_pkg::SEQ_RUN, 3'h6, 3'h7, 1'h1, 1'h0, 1'h0, 1'h1), 6, 2, 0, 0, 5);
        scan(cfg(mas_pkg::SEQ_RUN, 3'h1, 3'h2, 1'h0, 1'h1, 1'h1, 1'h1), 1, 1, 1, 1, 8);
        wr(cfg(2'h0, 3'h2, 3'h7, 1'h0, 1'h0, 1'h0, 1'h1));
        check({seq_running, chan}, 4'h2, "stop word");
        scan(cfg(mas_pkg::SEQ_RUN, 3'h7, 3'h7, 1'h0, 1'h0, 1'h0, 1'h1), 7, 1, 0, 0, 3);
        power_down_input = 1'h1;
        u_host.convert();
        #1;
        check(busy, 1'h0, "power down");
        #1 power_down_input = 1'h0;
        rst_n = 1'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({seq_running, gain}, 4'h7, "reset mid scan");
        rst_n = 1'h1;
        conv(16'h8000);
        check(result, 16'h0000, "after reset");
        $display("test power down and reset done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
